//--- design/fosg_cycle.sv
// Purpose: one asynchronous flash bus cycle (read or write) on the pins
// Assumes: dq_sync is the data bus after a two-flop synchroniser
// Notes:   chip select is released after every cycle, so address moves never
//          happen with both selects low
`timescale 1ns/1ps
module fosg_cycle (
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  input  wire logic                        start,
  input  wire logic                        wr,
  input  wire logic [fosg_pkg::ADDR_W-1:0] addr,
  input  wire logic [fosg_pkg::DATA_W-1:0] wdata,
  input  wire logic [fosg_pkg::DATA_W-1:0] dq_sync,
  output fosg_pkg::fosg_pins_s             pins,
  output logic                             done,
  output logic [fosg_pkg::DATA_W-1:0]      rdata
);

  typedef enum logic [1:0] {
    C_IDLE   = 2'b00,
    C_SETUP  = 2'b01,
    C_STROBE = 2'b10,
    C_HOLD   = 2'b11
  } fosg_cst_e;

  fosg_cst_e                   st_q, st_d;
  fosg_pkg::fosg_pins_s        pins_q, pins_d;
  logic [3:0]                  cnt_q, cnt_d;
  logic                        done_q, done_d;
  logic [fosg_pkg::DATA_W-1:0] rdata_q, rdata_d;

  // cycle sequencer: setup, strobe, release
  always_comb begin
    st_d    = st_q;
    pins_d  = pins_q;
    cnt_d   = cnt_q;
    done_d  = 1'b0;
    rdata_d = rdata_q;
    case (st_q)
      C_IDLE: begin
        if (start) begin
          pins_d.addr  = addr;
          pins_d.ce_n  = 1'b0;
          pins_d.dq_o  = wdata;
          pins_d.dq_oe = wr;
          st_d         = C_SETUP;
        end
      end
      C_SETUP: begin
        // a write strobe only falls while the output gate stays high
        if (pins_q.dq_oe) begin
          pins_d.we_n = 1'b0;
          cnt_d       = 4'(fosg_pkg::WP_CYC - 1);
        end else begin
          pins_d.oe_n = 1'b0;
          cnt_d       = 4'(fosg_pkg::ACC_CYC + fosg_pkg::SYNC_CYC - 1);
        end
        st_d = C_STROBE;
      end
      C_STROBE: begin
        if (cnt_q == 4'h0) begin
          if (!pins_q.dq_oe) begin
            rdata_d = dq_sync; // access time plus synchroniser delay elapsed
          end
          pins_d.oe_n = 1'b1;
          pins_d.we_n = 1'b1;
          pins_d.ce_n = 1'b1;
          st_d        = C_HOLD;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      C_HOLD: begin
        pins_d.dq_oe = 1'b0; // data held one cycle past the strobe
        done_d       = 1'b1;
        st_d         = C_IDLE;
      end
      default: st_d = C_IDLE;
    endcase
  end

  // idle pins: every select high so nothing reads as a write from reset on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q         <= C_IDLE;
      pins_q.ce_n  <= 1'b1;
      pins_q.oe_n  <= 1'b1;
      pins_q.we_n  <= 1'b1;
      pins_q.addr  <= '0;
      pins_q.dq_o  <= '0;
      pins_q.dq_oe <= 1'b0;
      cnt_q        <= 4'h0;
      done_q       <= 1'b0;
      rdata_q      <= '0;
    end else begin
      st_q    <= st_d;
      pins_q  <= pins_d;
      cnt_q   <= cnt_d;
      done_q  <= done_d;
      rdata_q <= rdata_d;
    end
  end

  assign pins  = pins_q;
  assign done  = done_q;
  assign rdata = rdata_q;

endmodule

//--- design/fosg_host.sv
// Purpose: host controller that reads, writes and toggle-polls a parallel flash
// Assumes: AHB-Lite slave, zero wait states, single word transfers only
// Notes:   software writes single bus cycles; command sequences are built by software
//
// Notes on behaviour
// - host keeps a select high whenever the bank address changes between reads
// - host starts polling with two back-to-back full reads and compares toggles
// - equal toggle bits mean done; the next read returns array data
// - toggling with time-limit bit high: re-check, then issue reset command
// - a host that stops polling restarts from the first two reads
// - a write needs chip select and write strobe low with output gate high
//
// Decided for this implementation: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module fosg_host #(
  parameter logic [15:0] POLL_LIMIT = fosg_pkg::POLL_MAX
) (
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic                             hreadyout,
  output logic                             hresp,
  output logic [31:0]                      hrdata,
  output logic                             flash_ce_n,
  output logic                             flash_oe_n,
  output logic                             flash_we_n,
  output logic [fosg_pkg::ADDR_W-1:0]      flash_addr,
  output logic [fosg_pkg::DATA_W-1:0]      flash_dq_o,
  output logic                             flash_dq_oe,
  input  wire logic [fosg_pkg::DATA_W-1:0] flash_dq_i,
  output logic                             flash_hw_reset_n,
  input  wire logic                        ready_busy_n_in
);

  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_CYC  = 3'b001,
    M_RD1  = 3'b010,
    M_RD2  = 3'b011,
    M_RD3  = 3'b100,
    M_RST  = 3'b101,
    M_ARR  = 3'b110
  } fosg_mst_e;

  // pin synchronisers
  logic [fosg_pkg::DATA_W-1:0] dq_s1_q, dq_s2_q;
  logic                        rb_s1_q, rb_s2_q;

  // bus slave state
  logic                        wr_pend_q, wr_pend_d;
  logic [7:0]                  waddr_q, waddr_d;
  logic [31:0]                 hrdata_q, hrdata_d;
  logic                        rst_q, rst_d;
  logic [fosg_pkg::ADDR_W-1:0] addr_q, addr_d;
  logic [fosg_pkg::DATA_W-1:0] wdata_q, wdata_d;
  logic                        go;
  fosg_pkg::fosg_op_e          go_op;

  // sequencer state
  fosg_mst_e                   state_q, state_d;
  logic                        start_q, start_d;
  logic                        cyc_wr_q, cyc_wr_d;
  logic [fosg_pkg::ADDR_W-1:0] cyc_addr_q, cyc_addr_d;
  logic [fosg_pkg::DATA_W-1:0] cyc_wdata_q, cyc_wdata_d;
  logic [fosg_pkg::DATA_W-1:0] first_q, first_d;
  logic [15:0]                 poll_cnt_q, poll_cnt_d;
  logic [fosg_pkg::DATA_W-1:0] rdata_q, rdata_d;
  logic                        ok_q, ok_d;
  logic                        fail_q, fail_d;
  logic                        gave_q, gave_d;
  logic                        tlim_q, tlim_d;
  logic                        alt2_q, alt2_d;

  // cycle engine outputs
  fosg_pkg::fosg_pins_s        pins;
  logic                        cyc_done;
  logic [fosg_pkg::DATA_W-1:0] cyc_rdata;
  logic                        same_alt;
  logic [31:0]                 stat_word;

  // two flops on every pin input before any logic looks at it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dq_s1_q <= '0;
      dq_s2_q <= '0;
      rb_s1_q <= 1'b1;
      rb_s2_q <= 1'b1;
    end else begin
      dq_s1_q <= flash_dq_i;
      dq_s2_q <= dq_s1_q;
      rb_s1_q <= ready_busy_n_in;
      rb_s2_q <= rb_s1_q;
    end
  end

  fosg_cycle u_cycle (
    .hclk    (hclk),
    .hresetn (hresetn),
    .start   (start_q),
    .wr      (cyc_wr_q),
    .addr    (cyc_addr_q),
    .wdata   (cyc_wdata_q),
    .dq_sync (dq_s2_q),
    .pins    (pins),
    .done    (cyc_done),
    .rdata   (cyc_rdata)
  );

  // status word seen by software
  always_comb begin
    stat_word                     = 32'h0000_0000;
    stat_word[fosg_pkg::ST_BUSY]  = (state_q != M_IDLE);
    stat_word[fosg_pkg::ST_OK]    = ok_q;
    stat_word[fosg_pkg::ST_FAIL]  = fail_q;
    stat_word[fosg_pkg::ST_READY] = rb_s2_q;
    stat_word[fosg_pkg::ST_GAVE]  = gave_q;
    stat_word[fosg_pkg::ST_TLIM]  = tlim_q;
    stat_word[fosg_pkg::ST_ALT2]  = alt2_q;
  end

  // bus slave: read data is picked in the address phase so no wait state is needed
  always_comb begin
    wr_pend_d = 1'b0;
    waddr_d   = waddr_q;
    hrdata_d  = hrdata_q;
    rst_d     = rst_q;
    addr_d    = addr_q;
    wdata_d   = wdata_q;
    if (hsel && hready && htrans[1]) begin
      wr_pend_d = hwrite;
      waddr_d   = haddr[7:0];
      hrdata_d  = 32'h0000_0000;
      if (!hwrite && (haddr[31:8] == 24'h00_0000)) begin
        case (haddr[7:0])
          fosg_pkg::OFF_CTRL:  hrdata_d[fosg_pkg::CTRL_RST_BIT] = rst_q;
          fosg_pkg::OFF_ADDR:  hrdata_d[fosg_pkg::ADDR_W-1:0] = addr_q;
          fosg_pkg::OFF_WDATA: hrdata_d[fosg_pkg::DATA_W-1:0] = wdata_q;
          fosg_pkg::OFF_STAT:  hrdata_d = stat_word;
          fosg_pkg::OFF_RDATA: hrdata_d[fosg_pkg::DATA_W-1:0] = rdata_q;
          default:             hrdata_d = 32'h0000_0000;
        endcase
      end
    end
    if (wr_pend_q) begin
      case (waddr_q)
        fosg_pkg::OFF_CTRL:  rst_d = hwdata[fosg_pkg::CTRL_RST_BIT];
        fosg_pkg::OFF_ADDR:  addr_d = hwdata[fosg_pkg::ADDR_W-1:0];
        fosg_pkg::OFF_WDATA: wdata_d = hwdata[fosg_pkg::DATA_W-1:0];
        default:             rst_d = rst_q;
      endcase
    end
  end

  // an operation may only be started while the sequencer is idle
  assign go_op = fosg_pkg::fosg_op_e'(hwdata[fosg_pkg::CTRL_OP_LSB +: 2]);
  assign go    = wr_pend_q && (waddr_q == fosg_pkg::OFF_CTRL) && (state_q == M_IDLE)
                 && (go_op != fosg_pkg::OP_NONE);

  // compares only the read alternating bit; the sector bit is reported, not judged
  assign same_alt = (cyc_rdata[fosg_pkg::DQ_ALT] == first_q[fosg_pkg::DQ_ALT]);

  // sequencer: single cycles and the toggle-bit polling procedure
  always_comb begin
    state_d     = state_q;
    start_d     = 1'b0;
    cyc_wr_d    = cyc_wr_q;
    cyc_addr_d  = cyc_addr_q;
    cyc_wdata_d = cyc_wdata_q;
    first_d     = first_q;
    poll_cnt_d  = poll_cnt_q;
    rdata_d     = rdata_q;
    ok_d        = ok_q;
    fail_d      = fail_q;
    gave_d      = gave_q;
    tlim_d      = tlim_q;
    alt2_d      = alt2_q;
    case (state_q)
      M_IDLE: begin
        if (go) begin
          ok_d        = 1'b0;
          fail_d      = 1'b0;
          gave_d      = 1'b0;
          tlim_d      = 1'b0;
          alt2_d      = 1'b0;
          poll_cnt_d  = 16'h0000;
          start_d     = 1'b1;
          cyc_addr_d  = addr_q;
          cyc_wdata_d = wdata_q;
          cyc_wr_d    = (go_op == fosg_pkg::OP_WRITE);
          // every poll begins afresh with two reads
          state_d     = (go_op == fosg_pkg::OP_POLL) ? M_RD1 : M_CYC;
        end
      end
      M_CYC: begin
        if (cyc_done) begin
          if (!cyc_wr_q) begin
            rdata_d = cyc_rdata;
          end
          ok_d    = 1'b1;
          state_d = M_IDLE;
        end
      end
      M_RD1: begin
        if (cyc_done) begin
          first_d = cyc_rdata;
          start_d = 1'b1;
          state_d = M_RD2;
        end
      end
      M_RD2: begin
        if (cyc_done) begin
          alt2_d  = (cyc_rdata[fosg_pkg::DQ_SECTALT] != first_q[fosg_pkg::DQ_SECTALT]);
          rdata_d = cyc_rdata;
          start_d = 1'b1;
          if (same_alt) begin
            state_d = M_ARR;
          end else if (cyc_rdata[fosg_pkg::DQ_TLIM]) begin
            tlim_d  = 1'b1;
            first_d = cyc_rdata;
            state_d = M_RD3;
          end else if (poll_cnt_q == POLL_LIMIT) begin
            start_d = 1'b0;
            gave_d  = 1'b1;
            state_d = M_IDLE;
          end else begin
            poll_cnt_d = poll_cnt_q + 16'h0001;
            state_d    = M_RD1;
          end
        end
      end
      M_RD3: begin
        if (cyc_done) begin
          rdata_d = cyc_rdata;
          start_d = 1'b1;
          if (same_alt) begin
            state_d = M_ARR;
          end else begin
            // still toggling after the limit flag: return the device to array reads
            cyc_wr_d    = 1'b1;
            cyc_wdata_d = fosg_pkg::CMD_RESET;
            state_d     = M_RST;
          end
        end
      end
      M_RST: begin
        if (cyc_done) begin
          cyc_wr_d = 1'b0;
          fail_d   = 1'b1;
          state_d  = M_IDLE;
        end
      end
      M_ARR: begin
        if (cyc_done) begin
          rdata_d = cyc_rdata;
          ok_d    = 1'b1;
          state_d = M_IDLE;
        end
      end
      default: state_d = M_IDLE;
    endcase
  end

  // registers of the bus slave and the sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q   <= 1'b0;
      waddr_q     <= 8'h00;
      hrdata_q    <= 32'h0000_0000;
      rst_q       <= 1'b0;
      addr_q      <= '0;
      wdata_q     <= '0;
      state_q     <= M_IDLE;
      start_q     <= 1'b0;
      cyc_wr_q    <= 1'b0;
      cyc_addr_q  <= '0;
      cyc_wdata_q <= '0;
      first_q     <= '0;
      poll_cnt_q  <= 16'h0000;
      rdata_q     <= '0;
      ok_q        <= 1'b0;
      fail_q      <= 1'b0;
      gave_q      <= 1'b0;
      tlim_q      <= 1'b0;
      alt2_q      <= 1'b0;
    end else begin
      wr_pend_q   <= wr_pend_d;
      waddr_q     <= waddr_d;
      hrdata_q    <= hrdata_d;
      rst_q       <= rst_d;
      addr_q      <= addr_d;
      wdata_q     <= wdata_d;
      state_q     <= state_d;
      start_q     <= start_d;
      cyc_wr_q    <= cyc_wr_d;
      cyc_addr_q  <= cyc_addr_d;
      cyc_wdata_q <= cyc_wdata_d;
      first_q     <= first_d;
      poll_cnt_q  <= poll_cnt_d;
      rdata_q     <= rdata_d;
      ok_q        <= ok_d;
      fail_q      <= fail_d;
      gave_q      <= gave_d;
      tlim_q      <= tlim_d;
      alt2_q      <= alt2_d;
    end
  end

  // handshake outputs and the reset pin: zero wait, always okay
  logic hreadyout_q;
  logic hw_reset_n_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_q  <= 1'b0;
      hw_reset_n_q <= 1'b1;
    end else begin
      hreadyout_q  <= 1'b1;
      hw_reset_n_q <= ~rst_q;
    end
  end

  assign hreadyout        = hreadyout_q;
  assign hresp            = 1'b0;
  assign hrdata           = hrdata_q;
  assign flash_ce_n       = pins.ce_n;
  assign flash_oe_n       = pins.oe_n;
  assign flash_we_n       = pins.we_n;
  assign flash_addr       = pins.addr;
  assign flash_dq_o       = pins.dq_o;
  assign flash_dq_oe      = pins.dq_oe;
  assign flash_hw_reset_n = hw_reset_n_q;

endmodule

//--- design/fosg_pkg.sv
// Purpose: shared constants and types for the flash status-polling host controller
// Assumes: 20 MHz hclk, 16-bit flash data bus, 21-bit word address
// Notes:   register offsets are byte addresses on the AHB-Lite slave
package fosg_pkg;

  // pin bus widths
  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;

  // timing, in ns as printed, and derived cycle counts (least times round up)
  localparam int CLK_NS    = 50;
  localparam int T_WP_NS   = 35;
  localparam int T_ACC_NS  = 70;
  localparam int WP_CYC    = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACC_CYC   = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_CYC  = 2;

  // register offsets
  localparam logic [7:0] OFF_CTRL  = 8'h00;
  localparam logic [7:0] OFF_ADDR  = 8'h04;
  localparam logic [7:0] OFF_WDATA = 8'h08;
  localparam logic [7:0] OFF_STAT  = 8'h0c;
  localparam logic [7:0] OFF_RDATA = 8'h10;

  // control fields
  localparam int CTRL_OP_LSB  = 0;
  localparam int CTRL_RST_BIT = 8;

  // status fields
  localparam int ST_BUSY  = 0;
  localparam int ST_OK    = 1;
  localparam int ST_FAIL  = 2;
  localparam int ST_READY = 3;
  localparam int ST_GAVE  = 4;
  localparam int ST_TLIM  = 5;
  localparam int ST_ALT2  = 6;

  // status bit positions on the flash data bus
  localparam int DQ_ALT     = 6;
  localparam int DQ_TLIM    = 5;
  localparam int DQ_SECTALT = 2;

  // reset command word and default poll budget
  localparam logic [DATA_W-1:0] CMD_RESET = 16'h00f0;
  localparam logic [15:0]       POLL_MAX  = 16'h0400;

  typedef enum logic [1:0] {
    OP_NONE  = 2'b00,
    OP_READ  = 2'b01,
    OP_WRITE = 2'b10,
    OP_POLL  = 2'b11
  } fosg_op_e;

  typedef struct packed {
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_o;
    logic              dq_oe;
  } fosg_pins_s;

endpackage

//--- dv/fosg_flash_model.sv
// Purpose: behavioural dual-bank flash with toggle status and ready/busy
// Assumes: bank is addr[11], sector addr[11:8], 4096 words modelled
// Notes:   busy time counted in status reads so polls are deterministic
`timescale 1ns/1ps
module fosg_flash_model #(
  parameter int PROG_READS  = 4,
  parameter int ERASE_READS = 16
) (
  input  wire logic                        ce_n,
  input  wire logic                        oe_n,
  input  wire logic                        we_n,
  input  wire logic [fosg_pkg::ADDR_W-1:0] addr,
  input  wire logic [fosg_pkg::DATA_W-1:0] dq_o,
  input  wire logic                        hw_reset_n,
  output logic      [fosg_pkg::DATA_W-1:0] dq_i,
  output logic                             rb_low
);
  logic [15:0] mem [4096];
  logic [15:0] rd_val;
  logic [15:0] op_d;
  logic [11:0] op_a;
  logic [3:0]  er_sec;
  logic [2:0]  step;
  logic        busy;
  logic        erasing;
  logic        stuck;
  logic        alt;
  logic        alt2;
  int          left;
  wire         rd_act = !ce_n && !oe_n;
  wire         wr_act = !ce_n && !we_n && oe_n;
  wire  [11:0] a      = addr[11:0];
  wire         in_op  = busy && a[11] == op_a[11];

  // power-up lands in array read mode
  initial begin
    for (int i = 0; i < 4096; i++) mem[i] = {4'hf, ~i[11:0]};
    {step, busy, erasing, stuck, alt, alt2} = '0;
    {op_a, op_d, er_sec} = '0;
    left = 0;
  end

  // status word only inside the bank that runs the operation
  always_comb begin
    rd_val = mem[a];
    if (in_op) begin
      rd_val = {8'h00, ~erasing & ~op_d[7], alt, stuck, 1'b0, erasing,
                ~erasing | ((a[11:8] == er_sec) & alt2), 2'b00};
    end
  end
  // a released bus shows the inverse, never a held value
  assign dq_i   = rd_act ? rd_val : ~rd_val;
  assign rb_low = busy || !hw_reset_n;

  // end of each select or gate pulse is one read
  always @(negedge rd_act) begin
    if (in_op) begin
      alt = ~alt;
      if (erasing && a[11:8] == er_sec) alt2 = ~alt2;
      if (!stuck) left--;
      if (!stuck && left == 0) begin
        busy = 1'b0;
        if (erasing) for (int i = 0; i < 256; i++) mem[{er_sec, i[7:0]}] = 16'hffff;
        erasing = 1'b0;
      end
    end
  end

  // command decoder; any wrong cycle drops back to the start
  // taken when the write cycle closes, so select and strobe may rise together
  always @(negedge wr_act) begin
    if (hw_reset_n) begin
      if (dq_o[7:0] == 8'hf0) begin
        step = 3'd0;
        if (stuck) {busy, stuck} = 2'b00;
      end else if (!busy) begin
        case (step)
          3'd0, 3'd3: step = (a == 12'h555 && dq_o[7:0] == 8'haa) ? step + 3'd1 : 3'd0;
          3'd1, 3'd4: step = (a == 12'h2aa && dq_o[7:0] == 8'h55) ? step + 3'd1 : 3'd0;
          3'd2: step = (a != 12'h555) ? 3'd0 : (dq_o[7:0] == 8'ha0) ? 3'd6 :
                       (dq_o[7:0] == 8'h80) ? 3'd3 : 3'd0;
          default: begin
            busy    = (step == 3'd6) || (dq_o[7:0] == 8'h30);
            erasing = (step == 3'd5) && busy;
            stuck   = (step == 3'd6) && |(dq_o & ~mem[a]);
            if (step == 3'd6 && !stuck) mem[a] = dq_o;
            op_a    = a;
            op_d    = dq_o;
            er_sec  = a[11:8];
            left    = erasing ? ERASE_READS : PROG_READS;
            step    = 3'd0;
          end
        endcase
      end
    end
  end

  // hardware reset aborts the operation; a cut erase leaves its sector unusable
  always @(negedge hw_reset_n) begin
    if (erasing) for (int i = 0; i < 256; i++) mem[{er_sec, i[7:0]}] = 'x;
    {step, busy, stuck, erasing} = '0;
  end
endmodule

//--- dv/fosg_host_assertions.sv
// Purpose: pin and bus relations of the flash host controller
// Assumes: one hclk domain, reset active low
// Notes:   watches only what the controller drives
`timescale 1ns/1ps
module fosg_host_assertions (
  input wire logic                        hclk,
  input wire logic                        hresetn,
  input wire logic                        hreadyout,
  input wire logic                        hresp,
  input wire logic                        flash_ce_n,
  input wire logic                        flash_oe_n,
  input wire logic                        flash_we_n,
  input wire logic [fosg_pkg::ADDR_W-1:0] flash_addr,
  input wire logic [fosg_pkg::DATA_W-1:0] flash_dq_o,
  input wire logic                        flash_dq_oe
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // the bank address may only move while the chip is deselected
  addr_hold_sel_a: assert property ((!flash_ce_n && !$past(flash_ce_n)) |-> $stable(flash_addr))
    else $error("flash address moved while selected");
  ce_gap_a: assert property ($rose(flash_ce_n) |=> flash_ce_n)
    else $error("chip select high for one cycle only");
  we_guard_a: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n && flash_dq_oe)
    else $error("write strobe without select, gate high and data driven");
  oe_guard_a: assert property (!flash_oe_n |-> !flash_ce_n && flash_we_n && !flash_dq_oe)
    else $error("output gate low while writing or driving data");
  we_pulse_a: assert property ($fell(flash_we_n) |=> $rose(flash_we_n) && $rose(flash_ce_n))
    else $error("write pulse not closed after one cycle");
  wdata_hold_a: assert property (!flash_we_n |-> $stable(flash_dq_o) && $stable(flash_addr))
    else $error("write data or address moved during strobe");
  read_len_a: assert property ($fell(flash_oe_n) |-> !flash_oe_n [*4] ##1 flash_oe_n)
    else $error("read strobe length wrong");
  ce_idle_a: assert property (flash_ce_n |-> flash_we_n && flash_oe_n)
    else $error("strobe active while deselected");
  bus_ready_a: assert property ($past(hresetn) |-> hreadyout && !hresp)
    else $error("bus not ready or error response");
endmodule

//--- dv/fosg_host_test.sv
// Purpose: self-checking bench for the flash host controller
// Assumes: poll budget shortened to 5 pairs
// Notes:   all flash traffic goes through the controller registers
`timescale 1ns/1ps
module fosg_host_test;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        ce_n;
  logic        oe_n;
  logic        we_n;
  logic        dq_oe;
  logic        hw_rst_n;
  logic        rb_low;
  logic [20:0] f_addr;
  logic [15:0] dq_o;
  logic [15:0] dq_i;
  logic [31:0] rd;
  int          bad_count;
  int          checks;
  logic [11:0] ua [5] = '{12'h555, 12'h2aa, 12'h555, 12'h555, 12'h2aa};
  logic [7:0]  ud [5] = '{8'haa, 8'h55, 8'h80, 8'haa, 8'h55};
  wire         rb_wire = rb_low ? 1'b0 : 1'b1; // open drain with pull-up

  // clock at 20 MHz
  initial hclk = 1'b0;
  always #25 hclk = ~hclk;

  fosg_host #(.POLL_LIMIT(16'h0004)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .flash_ce_n(ce_n),
    .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_addr(f_addr), .flash_dq_o(dq_o),
    .flash_dq_oe(dq_oe), .flash_dq_i(dq_i), .flash_hw_reset_n(hw_rst_n),
    .ready_busy_n_in(rb_wire));

  fosg_flash_model #(.PROG_READS(5), .ERASE_READS(22)) flash_u (
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(f_addr), .dq_o(dq_o),
    .hw_reset_n(hw_rst_n), .dq_i(dq_i), .rb_low(rb_low));

  task final_report;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // one single-word transfer; the bound on both phases cuts a hang
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    hwrite <= wr;
    htrans <= 2'b10;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= wd;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 100);
    q = hrdata;
    if (n >= 100) begin bad_count++; final_report; end
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk);
    checks++;
    if ((got & msk) !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // start one controller operation and wait for it to finish
  task op(input logic [1:0] kind, input logic [20:0] fa, input logic [15:0] fd);
    int n;
    n = 0;
    ahb(1'b1, fosg_pkg::OFF_ADDR, {11'h000, fa}, rd);
    ahb(1'b1, fosg_pkg::OFF_WDATA, {16'h0000, fd}, rd);
    ahb(1'b1, fosg_pkg::OFF_CTRL, {30'h0000_0000, kind}, rd);
    do begin ahb(1'b0, fosg_pkg::OFF_STAT, 32'h0000_0000, rd); n++; end
    while (rd[0] !== 1'b0 && n < 300);
    if (n >= 300) begin bad_count++; final_report; end
  endtask

  task cmds(input int cnt);
    for (int i = 0; i < cnt; i++) op(fosg_pkg::OP_WRITE, {9'h000, ua[i]}, {8'h00, ud[i]});
  endtask

  task fread(input logic [20:0] fa);
    op(fosg_pkg::OP_READ, fa, 16'h0000);
    ahb(1'b0, fosg_pkg::OFF_RDATA, 32'h0000_0000, rd);
  endtask

  task stat;
    ahb(1'b0, fosg_pkg::OFF_STAT, 32'h0000_0000, rd);
  endtask

  // main sequence: registers, partial command, program, failed program, erase, pin reset
  initial begin
    {hresetn, hsel, haddr, htrans, hwrite, hwdata, bad_count, checks} = '0;
    hsize = 3'b010;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (fosg_pkg::SYNC_CYC + 2) @(posedge hclk);
    stat; chk(rd, 32'h0000_0008, 32'hffff_ffff);
    ahb(1'b1, fosg_pkg::OFF_ADDR, 32'h001a_bcde, rd);
    ahb(1'b0, fosg_pkg::OFF_ADDR, 32'h0000_0000, rd); chk(rd, 32'h001a_bcde, 32'hffff_ffff);
    ahb(1'b0, 8'h20, 32'h0000_0000, rd); chk(rd, 32'h0000_0000, 32'hffff_ffff);
    fread(21'h0_0100); chk(rd, 32'h0000_feff, 32'hffff_ffff);
    cmds(2);
    op(fosg_pkg::OP_WRITE, 21'h0_0100, 16'h0012);
    fread(21'h0_0100); chk(rd, 32'h0000_feff, 32'hffff_ffff);
    cmds(2);
    op(fosg_pkg::OP_WRITE, 21'h0_0555, 16'h00a0);
    op(fosg_pkg::OP_WRITE, 21'h0_0040, 16'h0034);
    stat; chk(rd, 32'h0000_0000, 32'h0000_0008);
    fread(21'h0_0840); chk(rd, 32'h0000_f7bf, 32'hffff_ffff);
    fread(21'h0_0040); chk(rd, 32'h0000_0084, 32'h0000_00a4);
    op(fosg_pkg::OP_POLL, 21'h0_0040, 16'h0000);
    stat; chk(rd, 32'h0000_000a, 32'hffff_ffff);
    ahb(1'b0, fosg_pkg::OFF_RDATA, 32'h0000_0000, rd); chk(rd, 32'h0000_0034, 32'hffff_ffff);
    cmds(2);
    op(fosg_pkg::OP_WRITE, 21'h0_0555, 16'h00a0);
    op(fosg_pkg::OP_WRITE, 21'h0_0041, 16'h0040);
    op(fosg_pkg::OP_POLL, 21'h0_0041, 16'h0000);
    stat; chk(rd, 32'h0000_0024, 32'hffff_fff7);
    fread(21'h0_0041); chk(rd, 32'h0000_ffbe, 32'hffff_ffff);
    cmds(5);
    op(fosg_pkg::OP_WRITE, 21'h0_0300, 16'h0030);
    op(fosg_pkg::OP_POLL, 21'h0_0410, 16'h0000);
    stat; chk(rd, 32'h0000_0010, 32'hffff_ffff);
    op(fosg_pkg::OP_POLL, 21'h0_0300, 16'h0000);
    stat; chk(rd, 32'h0000_0050, 32'hffff_ffff);
    op(fosg_pkg::OP_POLL, 21'h0_0300, 16'h0000);
    stat; chk(rd, 32'h0000_000a, 32'hffff_ffff);
    fread(21'h0_03a5); chk(rd, 32'h0000_ffff, 32'hffff_ffff);
    ahb(1'b1, fosg_pkg::OFF_CTRL, 32'h0000_0100, rd);
    repeat (fosg_pkg::SYNC_CYC + 2) @(posedge hclk);
    stat; chk(rd, 32'h0000_0000, 32'h0000_0008);
    ahb(1'b1, fosg_pkg::OFF_CTRL, 32'h0000_0000, rd);
    repeat (fosg_pkg::SYNC_CYC + 2) @(posedge hclk);
    stat; chk(rd, 32'h0000_0008, 32'h0000_0008);
    final_report;
  end
endmodule

bind fosg_host fosg_host_assertions chk_u (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
  .flash_addr(flash_addr), .flash_dq_o(flash_dq_o), .flash_dq_oe(flash_dq_oe));
